/* logic/jtcid_top.sv */
/*
 * Test access port chain of one device: a boundary TAP and a chip TAP per
 * tile, wired in series, plus global reset, boot sequencing and the core
 * side of chip access. Assumes tck_i from the tester may stop between scans and
 * that core request inputs are synchronous to core_clk_i.
 */
`timescale 1ns/1ps
module jtcid_top (
    input  wire logic                          core_clk_i,
    input  wire logic                          rstn_i,
    input  wire logic                          tck_i,
    input  wire logic                          trstn_i,
    input  wire logic                          tms_i,
    input  wire logic                          tdi_i,
    output logic                               tdo_o,
    output logic                               tdo_oe_o,
    input  wire logic [jtcid_pkg::BSR_W-1:0]   pin_in_i,
    input  wire logic [jtcid_pkg::BSR_W-1:0]   pin_core_i,
    output logic      [jtcid_pkg::BSR_W-1:0]   pin_out_o,
    input  wire logic [jtcid_pkg::WORD_W-1:0]  sec_reg_i,
    input  wire logic                          otp_blank_i,
    input  wire logic                          pll_lock_i,
    input  wire logic [jtcid_pkg::MODE_W-1:0]  boot_mode_i,
    output logic      [jtcid_pkg::MODE_W-1:0]  boot_mode_o,
    output logic                               boot_start_o,
    output logic                               booted_o,
    output logic                               dbg_req_o,
    output logic                               dbg_tile_o,
    output logic      [jtcid_pkg::TGT_W-1:0]   dbg_target_o,
    output logic                               dbg_write_o,
    output logic      [jtcid_pkg::ADDR_W-1:0]  dbg_addr_o,
    output logic      [jtcid_pkg::WORD_W-1:0]  dbg_wdata_o,
    input  wire logic                          dbg_done_i,
    input  wire logic [jtcid_pkg::WORD_W-1:0]  dbg_rdata_i
);
    import jtcid_pkg::*;

    wire  [NUM_TAPS:0]        chain_w;
    wire  [NUM_TAPS-1:0]      oe_w;
    wire  [NUM_TAPS-1:0]      ext_w;
    wire  [NUM_TAPS-1:0]      req_w;
    wire  [NUM_TAPS*BSR_W-1:0] bupd_w;
    wire  [NUM_TAPS*DR_W-1:0] cmd_w;
    logic [1:0]               rst_s_r;
    logic                     rst_q;
    logic [USR_W-1:0]         usr_r, usr_nxt, usr1_r, usr2_r;
    logic [BSR_W-1:0]         pin1_r, pin2_r;
    logic [NUM_TILES-1:0]     ack_r, ack_nxt, pend_w;
    logic [NUM_TILES*WORD_W-1:0] rd_r, rd_nxt;

    assign chain_w[0] = tdi_i;
    assign tdo_o      = chain_w[NUM_TAPS];
    assign tdo_oe_o   = oe_w[NUM_TAPS-1];

    // global reset: asynchronous entry, synchronous release
    always_ff @(posedge core_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            rst_s_r <= 2'h0;
        end else begin
            rst_s_r <= {rst_s_r[0], 1'b1};
        end
    end
    assign rst_q = rst_s_r[1];

    // tck-side synchronisers for user id and pin samples
    always_ff @(posedge tck_i or negedge trstn_i) begin
        if (!trstn_i) begin
            usr1_r <= '0;
            usr2_r <= '0;
            pin1_r <= '0;
            pin2_r <= '0;
        end else begin
            usr1_r <= usr_r;
            usr2_r <= usr1_r;
            pin1_r <= pin_in_i;
            pin2_r <= pin1_r;
        end
    end

    // one TAP per chain position: even is boundary, odd is chip
    for (genvar k = 0; k < NUM_TAPS; k++) begin : g_tap
        localparam bit IS_CHIP = (k % 2) == 1;
        localparam int TILE    = k / 2;
        jtcid_tap_type      st_r, st_nxt;
        logic [IR_W-1:0]    ir_r, ir_nxt, irs_r, irs_nxt;
        logic [DR_W-1:0]    dr_r, dr_nxt, cmd_r, cmd_nxt;
        logic [BSR_W-1:0]   bupd_r, bupd_nxt;
        logic               req_r, req_nxt, ext_r, ext_nxt;
        logic               tdo_r, oe_r;
        logic [1:0]         ack_s_r;
        int                 len;

        // state, instruction and data register next values
        always_comb begin
            len      = 1;
            st_nxt   = st_r;
            ir_nxt   = ir_r;
            irs_nxt  = irs_r;
            dr_nxt   = dr_r;
            cmd_nxt  = cmd_r;
            bupd_nxt = bupd_r;
            req_nxt  = req_r;
            // selected register length, unsupported codes fall to bypass
            if (ir_r == IR_DEVICE_IDENTIFICATION_WORD || ir_r == IR_USERCODE) begin
                len = WORD_W;
            end else if (!IS_CHIP && (ir_r == IR_EXTEST || ir_r == IR_SAMPLE)) begin
                len = BSR_W;
            end else if (IS_CHIP && ir_r == IR_CHIPACC) begin
                len = DR_W;
            end
            case (st_r)
                T_RESET: st_nxt = tms_i ? T_RESET : T_IDLE;
                T_IDLE:  st_nxt = tms_i ? T_SELDR : T_IDLE;
                T_SELDR: st_nxt = tms_i ? T_SELIR : T_CAPDR;
                T_CAPDR: st_nxt = tms_i ? T_EX1DR : T_SHDR;
                T_SHDR:  st_nxt = tms_i ? T_EX1DR : T_SHDR;
                T_EX1DR: st_nxt = tms_i ? T_UPDR  : T_PADR;
                T_PADR:  st_nxt = tms_i ? T_EX2DR : T_PADR;
                T_EX2DR: st_nxt = tms_i ? T_UPDR  : T_SHDR;
                T_UPDR:  st_nxt = tms_i ? T_SELDR : T_IDLE;
                T_SELIR: st_nxt = tms_i ? T_RESET : T_CAPIR;
                T_CAPIR: st_nxt = tms_i ? T_EX1IR : T_SHIR;
                T_SHIR:  st_nxt = tms_i ? T_EX1IR : T_SHIR;
                T_EX1IR: st_nxt = tms_i ? T_UPIR  : T_PAIR;
                T_PAIR:  st_nxt = tms_i ? T_EX2IR : T_PAIR;
                T_EX2IR: st_nxt = tms_i ? T_UPIR  : T_SHIR;
                T_UPIR:  st_nxt = tms_i ? T_SELDR : T_IDLE;
                default: st_nxt = T_RESET;
            endcase
            case (st_r)
                T_RESET: ir_nxt = IR_DEVICE_IDENTIFICATION_WORD;
                T_CAPIR: irs_nxt = IR_CAPT;
                T_SHIR:  irs_nxt = {chain_w[k], irs_r[IR_W-1:1]};
                T_UPIR:  ir_nxt = irs_r;
                T_CAPDR: begin
                    dr_nxt = '0;
                    if (ir_r == IR_DEVICE_IDENTIFICATION_WORD) begin
                        dr_nxt[WORD_W-1:0] = DEVICE_IDENTIFICATION_WORD_VAL;
                    end else if (ir_r == IR_USERCODE) begin
                        dr_nxt[WORD_W-1:0] = {usr2_r, {UNUSED_W{1'b0}}, SIL_REV};
                    end else if (len == BSR_W) begin
                        dr_nxt[BSR_W-1:0] = pin2_r;
                    end else if (len == DR_W) begin
                        dr_nxt = cmd_r;
                        if (ack_s_r[1] == req_r) begin
                            dr_nxt[F_DATA_LO +: WORD_W] = rd_r[TILE*WORD_W +: WORD_W];
                        end
                    end
                end
                T_SHDR: begin
                    dr_nxt = dr_r >> 1;
                    dr_nxt[len-1] = chain_w[k];
                end
                T_UPDR: begin
                    if (len == BSR_W) begin
                        bupd_nxt = dr_r[BSR_W-1:0];
                    end else if (len == DR_W && ack_s_r[1] == req_r) begin
                        cmd_nxt = dr_r;
                        req_nxt = ~req_r;
                    end
                end
                default: ;
            endcase
            ext_nxt = !IS_CHIP && (ir_nxt == IR_EXTEST);
        end

        // test reset held low keeps the whole TAP in reset
        always_ff @(posedge tck_i or negedge trstn_i) begin
            if (!trstn_i) begin
                st_r    <= T_RESET;
                ir_r    <= IR_DEVICE_IDENTIFICATION_WORD;
                irs_r   <= '0;
                dr_r    <= '0;
                cmd_r   <= '0;
                bupd_r  <= '0;
                req_r   <= 1'b0;
                ext_r   <= 1'b0;
                ack_s_r <= 2'h0;
            end else begin
                st_r    <= st_nxt;
                ir_r    <= ir_nxt;
                irs_r   <= irs_nxt;
                dr_r    <= dr_nxt;
                cmd_r   <= cmd_nxt;
                bupd_r  <= bupd_nxt;
                req_r   <= req_nxt;
                ext_r   <= ext_nxt;
                ack_s_r <= {ack_s_r[0], ack_r[TILE]};
            end
        end

        // test data out changes on the falling edge
        always_ff @(negedge tck_i or negedge trstn_i) begin
            if (!trstn_i) begin
                tdo_r <= 1'b0;
                oe_r  <= 1'b0;
            end else begin
                oe_r  <= (st_r == T_SHIR) || (st_r == T_SHDR);
                if (st_r == T_SHIR) begin
                    tdo_r <= irs_r[0];
                end else if (st_r == T_SHDR) begin
                    tdo_r <= dr_r[0];
                end
            end
        end

        assign chain_w[k+1]            = tdo_r;
        assign oe_w[k]                 = oe_r;
        assign ext_w[k]                = ext_r;
        assign req_w[k]                = req_r;
        assign bupd_w[k*BSR_W +: BSR_W] = bupd_r;
        assign cmd_w[k*DR_W +: DR_W]   = cmd_r;
    end

    // core-side request synchronisers, one per chip TAP
    for (genvar t = 0; t < NUM_TILES; t++) begin : g_req
        logic [1:0] rq_s_r;
        always_ff @(posedge core_clk_i) begin
            if (!rst_q) begin
                rq_s_r <= 2'h0;
            end else begin
                rq_s_r <= {rq_s_r[0], req_w[2*t+1]};
            end
        end
        assign pend_w[t] = rq_s_r[1] ^ ack_r[t];
    end

    jtcid_boot_type         boot_r, boot_nxt;
    jtcid_dbg_type          dst_r, dst_nxt;
    logic [1:0]             lock_s_r, ext_s_r;
    logic [BSR_W-1:0]       bnd1_r, bnd2_r, pin_out_nxt;
    logic [MODE_W-1:0]      mode1_r, mode2_r, mode_nxt;
    logic                   start_nxt, tile_nxt, dreq_nxt, wr_nxt;
    logic [TGT_W-1:0]       tgt_nxt;
    logic [ADDR_W-1:0]      addr_nxt;
    logic [WORD_W-1:0]      wdata_nxt;
    logic [DR_W-1:0]        sel_cmd;

    // core next values: boot, chip access and pin drive
    always_comb begin
        boot_nxt    = boot_r;
        start_nxt   = 1'b0;
        mode_nxt    = boot_mode_o;
        dst_nxt     = dst_r;
        ack_nxt     = ack_r;
        rd_nxt      = rd_r;
        dreq_nxt    = 1'b0;
        tile_nxt    = dbg_tile_o;
        tgt_nxt     = dbg_target_o;
        wr_nxt      = dbg_write_o;
        addr_nxt    = dbg_addr_o;
        wdata_nxt   = dbg_wdata_o;
        sel_cmd     = cmd_w[(2*(pend_w[0] ? 0 : 1)+1)*DR_W +: DR_W];
        usr_nxt     = otp_blank_i ? '0 : sec_reg_i[USR_LO +: USR_W];
        pin_out_nxt = ext_s_r[1] ? bnd2_r : pin_core_i;
        case (boot_r)
            B_HOLD: begin
                mode_nxt = mode2_r;                                    // strap taken at release
                boot_nxt = B_LOCK;
            end
            B_LOCK: begin
                if (lock_s_r[1]) begin
                    boot_nxt  = B_RUN;
                    start_nxt = 1'b1;
                end
            end
            B_RUN:   ;
            default: boot_nxt = B_HOLD;
        endcase
        case (dst_r)
            D_IDLE: begin
                if (|pend_w) begin
                    tile_nxt  = !pend_w[0];
                    tgt_nxt   = sel_cmd[F_TGT_LO +: TGT_W];
                    wr_nxt    = sel_cmd[F_WR];
                    addr_nxt  = sel_cmd[F_ADDR_LO +: ADDR_W];
                    wdata_nxt = sel_cmd[F_DATA_LO +: WORD_W];
                    dreq_nxt  = 1'b1;
                    dst_nxt   = D_WAIT;
                end
            end
            D_WAIT: begin
                if (dbg_done_i) begin
                    rd_nxt[32'(dbg_tile_o)*WORD_W +: WORD_W] = dbg_rdata_i;
                    ack_nxt[dbg_tile_o] = ~ack_r[dbg_tile_o];
                    dst_nxt = D_IDLE;
                end
            end
            default: dst_nxt = D_IDLE;
        endcase
    end

    // strap synchroniser runs through reset so the first free cycle sees the pin
    always_ff @(posedge core_clk_i) begin
        mode1_r <= boot_mode_i;
        mode2_r <= mode1_r;
    end

    // core registers, cleared at once when the global reset falls
    always_ff @(posedge core_clk_i or negedge rst_q) begin
        if (!rst_q) begin
            boot_r       <= B_HOLD;
            boot_start_o <= 1'b0;
            booted_o     <= 1'b0;
            boot_mode_o  <= '0;
            dst_r        <= D_IDLE;
            ack_r        <= '0;
            rd_r         <= '0;
            dbg_req_o    <= 1'b0;
            dbg_tile_o   <= 1'b0;
            dbg_target_o <= TGT_TILE;
            dbg_write_o  <= 1'b0;
            dbg_addr_o   <= '0;
            dbg_wdata_o  <= '0;
            usr_r        <= '0;
            pin_out_o    <= '0;
            lock_s_r     <= 2'h0;
            ext_s_r      <= 2'h0;
            bnd1_r       <= '0;
            bnd2_r       <= '0;
        end else begin
            boot_r       <= boot_nxt;
            boot_start_o <= start_nxt;
            booted_o     <= (boot_nxt == B_RUN);
            boot_mode_o  <= mode_nxt;
            dst_r        <= dst_nxt;
            ack_r        <= ack_nxt;
            rd_r         <= rd_nxt;
            dbg_req_o    <= dreq_nxt;
            dbg_tile_o   <= tile_nxt;
            dbg_target_o <= tgt_nxt;
            dbg_write_o  <= wr_nxt;
            dbg_addr_o   <= addr_nxt;
            dbg_wdata_o  <= wdata_nxt;
            usr_r        <= usr_nxt;
            pin_out_o    <= pin_out_nxt;
            lock_s_r     <= {lock_s_r[0], pll_lock_i};
            ext_s_r      <= {ext_s_r[0], ext_w[0]};
            bnd1_r       <= bupd_w[BSR_W-1:0];
            bnd2_r       <= bnd1_r;
        end
    end
endmodule

/* pkg/jtcid_pkg.sv */
/*
 * Shared constants, instruction codes and state types for the test access
 * port chain. Assumes a single test clock and test reset feed every TAP.
 */
package jtcid_pkg;
    localparam int NUM_TILES = 2;
    localparam int NUM_TAPS  = 2 * NUM_TILES;
    localparam int IR_W      = 4;
    localparam int BSR_W     = 8;
    localparam int WORD_W    = 32;
    localparam int ADDR_W    = 8;
    localparam int TGT_W     = 2;
    localparam int DR_W      = TGT_W + 1 + ADDR_W + WORD_W;
    localparam int MODE_W    = 2;
    // chip access register fields
    localparam int F_DATA_LO = 0;
    localparam int F_ADDR_LO = WORD_W;
    localparam int F_WR      = WORD_W + ADDR_W;
    localparam int F_TGT_LO  = F_WR + 1;
    // user code fields
    localparam int USR_LO    = 22;
    localparam int USR_W     = 10;
    localparam int REV_W     = 16;
    localparam int UNUSED_W  = WORD_W - USR_W - REV_W;
    // identity values: arbitrary, neutral
    localparam logic [31:0]      DEVICE_IDENTIFICATION_WORD_VAL = 32'h1000_0ABD;
    localparam logic [REV_W-1:0] SIL_REV    = 16'h0001;
    localparam logic [IR_W-1:0] IR_EXTEST   = 4'h0;
    localparam logic [IR_W-1:0] IR_DEVICE_IDENTIFICATION_WORD   = 4'h1;
    localparam logic [IR_W-1:0] IR_USERCODE = 4'h2;
    localparam logic [IR_W-1:0] IR_SAMPLE   = 4'h3;
    localparam logic [IR_W-1:0] IR_CHIPACC  = 4'h8;
    localparam logic [IR_W-1:0] IR_BYPASS   = 4'hF;
    localparam logic [IR_W-1:0] IR_CAPT     = 4'h1;
    localparam logic [TGT_W-1:0] TGT_TILE   = 2'h0;
    localparam logic [TGT_W-1:0] TGT_SWITCH = 2'h1;
    localparam logic [TGT_W-1:0] TGT_OTP    = 2'h2;

    typedef enum logic [3:0] {
        T_RESET = 4'h0, T_IDLE  = 4'h1, T_SELDR = 4'h3, T_CAPDR = 4'h2,
        T_SHDR  = 4'h6, T_EX1DR = 4'h7, T_PADR  = 4'h5, T_EX2DR = 4'h4,
        T_UPDR  = 4'hC, T_SELIR = 4'hD, T_CAPIR = 4'hF, T_SHIR  = 4'hE,
        T_EX1IR = 4'hA, T_PAIR  = 4'hB, T_EX2IR = 4'h9, T_UPIR  = 4'h8
    } jtcid_tap_type;

    typedef enum logic [1:0] {
        B_HOLD = 2'h0, B_LOCK = 2'h1, B_RUN = 2'h3
    } jtcid_boot_type;

    typedef enum logic [1:0] {
        D_IDLE = 2'h0, D_WAIT = 2'h1
    } jtcid_dbg_type;
endpackage

/* tb/jtcid_tester.sv */
/*
 * external jtag tester model: drives tck only while scanning.
 * assumes a chain of four 4-bit IR taps between tdi and tdo.
 */
`timescale 1ns/1ps
module jtcid_tester (
    output logic      tck_o,
    output logic      tms_o,
    output logic      tdi_o,
    output logic      trstn_o,
    input  wire logic tdo_i
);
    // clock still, test reset held until told otherwise
    initial begin
        tck_o   = 1'b0;
        tms_o   = 1'b1;
        tdi_o   = 1'b0;
        trstn_o = 1'b0;
    end
    // one tck period; tdo taken at the rising edge
    task automatic step(input logic tms, input logic tdi, output logic tdo);
        tms_o = tms;
        tdi_o = tdi;
        #16 tdo = tdo_i;
        tck_o = 1'b1;
        #16 tck_o = 1'b0;
    endtask
    // hold test reset low, no clocking
    task automatic hold_reset();
        trstn_o = 1'b0;
    endtask
    // test reset low over 100 ns, then walk to idle
    task automatic tap_reset();
        logic b;
        trstn_o = 1'b0;
        #103 trstn_o = 1'b1;
        step(1'b0, 1'b0, b);
    endtask
    // from idle: scan n bits lsb first, back to idle; tdi toggles off shift
    task automatic scan(input logic ir, input int n, input logic [127:0] din,
                        output logic [127:0] dout);
        logic b;
        dout = '0;
        #3;
        repeat (2) step(1'b0, ~tdi_o, b);
        step(1'b1, ~tdi_o, b);
        if (ir) step(1'b1, ~tdi_o, b);
        repeat (2) step(1'b0, ~tdi_o, b);
        for (int i = 0; i < n; i++) step(i == n - 1, din[i], dout[i]);
        step(1'b1, ~tdi_o, b);
        step(1'b0, ~tdi_o, b);
    endtask
endmodule

/* tb/jtcid_top_monitor.sv */
/*
 * concurrent checks on the tap chain top ports.
 * assumes it is bound onto jtcid_top.
 */
`timescale 1ns/1ps
module jtcid_top_monitor (
    input wire logic                         core_clk_i,
    input wire logic                         rstn_i,
    input wire logic                         trstn_i,
    input wire logic                         tdo_o,
    input wire logic                         tdo_oe_o,
    input wire logic [jtcid_pkg::BSR_W-1:0]  pin_core_i,
    input wire logic [jtcid_pkg::BSR_W-1:0]  pin_out_o,
    input wire logic                         pll_lock_i,
    input wire logic                         boot_start_o,
    input wire logic                         booted_o,
    input wire logic                         dbg_req_o,
    input wire logic [jtcid_pkg::TGT_W-1:0]  dbg_target_o,
    input wire logic [jtcid_pkg::ADDR_W-1:0] dbg_addr_o,
    input wire logic [jtcid_pkg::WORD_W-1:0] dbg_wdata_o
);
    import jtcid_pkg::*;
    default clocking @(posedge core_clk_i); endclocking
    default disable iff (!rstn_i);
    // tap output quiet while test reset held
    chk_trst_quiet: assert property (!trstn_i && !$past(trstn_i) |-> !tdo_oe_o && !tdo_o)
        else $error("tap output active in test reset");
    // boot state cleared by global reset
    chk_boot_cleared: assert property ($rose(rstn_i) |-> !booted_o && !boot_start_o)
        else $error("boot state survived reset");
    // boot only once lock is seen
    chk_boot_lock: assert property (boot_start_o |-> $past(pll_lock_i) && $past(pll_lock_i, 2))
        else $error("boot started without lock");
    chk_start_pulse: assert property (boot_start_o |=> !boot_start_o)
        else $error("boot start longer than one cycle");
    chk_booted_holds: assert property (booted_o |=> booted_o)
        else $error("booted dropped without reset");
    chk_booted_rise: assert property ($rose(booted_o) |-> boot_start_o)
        else $error("booted rose without boot start");
    // request fields hold between requests
    chk_fields_stable: assert property (!dbg_req_o |-> $stable(dbg_addr_o) && $stable(dbg_wdata_o)
        && $stable(dbg_target_o))
        else $error("request fields moved without request");
    // pins carry functional drive while test reset held
    chk_pin_follow: assert property ((!trstn_i && $stable(pin_core_i)) [*6]
        |-> pin_out_o == pin_core_i)
        else $error("pin output differs from core drive");
    cov_boot: cover property (boot_start_o);
    cov_req: cover property (dbg_req_o);
    cov_shift: cover property ($rose(tdo_oe_o));
endmodule
bind jtcid_top jtcid_top_monitor u_mon (.core_clk_i(core_clk_i), .rstn_i(rstn_i),
    .trstn_i(trstn_i), .tdo_o(tdo_o), .tdo_oe_o(tdo_oe_o), .pin_core_i(pin_core_i),
    .pin_out_o(pin_out_o), .pll_lock_i(pll_lock_i), .boot_start_o(boot_start_o),
    .booted_o(booted_o), .dbg_req_o(dbg_req_o), .dbg_target_o(dbg_target_o),
    .dbg_addr_o(dbg_addr_o), .dbg_wdata_o(dbg_wdata_o));

/* tb/jtag_tap_chain_ident_tb.sv */
/*
 * self-checking bench for the tap chain: boot, id words, chip access.
 * assumes the tester model drives the jtag pins.
 */
`timescale 1ns/1ps
`define CHK(a, b) begin samples_checked++; if ((a) !== (b)) begin miscompares++; \
    $display("mismatch at %0t: got %0h expected %0h", $time, (a), (b)); end end
module jtag_tap_chain_ident_tb;
    import jtcid_pkg::*;
    logic                core_clk_i = 1'b0;
    logic                rstn_i, tck_i, trstn_i, tms_i, tdi_i, tdo_o, tdo_oe_o;
    logic [BSR_W-1:0]    pin_in_i, pin_core_i, pin_out_o;
    logic [WORD_W-1:0]   sec_reg_i, dbg_wdata_o, dbg_rdata_i;
    logic                otp_blank_i, pll_lock_i, boot_start_o, booted_o;
    logic [MODE_W-1:0]   boot_mode_i, boot_mode_o;
    logic                dbg_req_o, dbg_tile_o, dbg_write_o, dbg_done_i;
    logic [TGT_W-1:0]    dbg_target_o;
    logic [ADDR_W-1:0]   dbg_addr_o;
    logic [43:0]         s_req;
    logic [127:0]        d;
    int                  miscompares = 0;
    int                  samples_checked = 0;
    int                  boots = 0;
    int                  reqs = 0;

    always #4 core_clk_i = ~core_clk_i;
    jtcid_top uut (.core_clk_i, .rstn_i, .tck_i, .trstn_i, .tms_i, .tdi_i, .tdo_o,
        .tdo_oe_o, .pin_in_i, .pin_core_i, .pin_out_o, .sec_reg_i, .otp_blank_i,
        .pll_lock_i, .boot_mode_i, .boot_mode_o, .boot_start_o, .booted_o, .dbg_req_o,
        .dbg_tile_o, .dbg_target_o, .dbg_write_o, .dbg_addr_o, .dbg_wdata_o, .dbg_done_i,
        .dbg_rdata_i);
    jtcid_tester u_tester (.tck_o(tck_i), .tms_o(tms_i), .tdi_o(tdi_i), .trstn_o(trstn_i),
        .tdo_i(tdo_o));
    // count boot pulses, latch each debug request
    always @(posedge core_clk_i) begin
        if (boot_start_o === 1'b1) boots <= boots + 1;
        if (dbg_req_o === 1'b1) begin
            reqs  <= reqs + 1;
            s_req <= {dbg_tile_o, dbg_target_o, dbg_write_o, dbg_addr_o, dbg_wdata_o};
        end
    end
    task automatic end_test(input string s);
        $display("test %s finished", s);
    endtask
    // boot waits for lock; reset clears at once
    task automatic t_boot();
        for (int k = 1; k <= 2; k++) begin
            repeat (10) @(negedge core_clk_i);
            `CHK(booted_o, 1'b0)
            pll_lock_i = 1'b1;
            for (int i = 0; i < 20 && booted_o !== 1'b1; i++) @(negedge core_clk_i);
            `CHK(booted_o, 1'b1)
            @(negedge core_clk_i); // pulse counter settles one edge later
            `CHK(boots, k)
            `CHK(boot_mode_o, k[1:0])
            rstn_i = 1'b0;
            pll_lock_i = 1'b0;
            #1 `CHK(booted_o, 1'b0)
            repeat (13) @(negedge core_clk_i);
            boot_mode_i = 2'h2;
            rstn_i = 1'b1;
        end
        end_test("boot");
    endtask
    // four id words follow tap reset
    task automatic t_device_identification_word();
        u_tester.tap_reset();
        u_tester.scan(1'b0, 128, '0, d);
        for (int k = 0; k < 4; k++) `CHK(d[32*k +: 32], DEVICE_IDENTIFICATION_WORD_VAL)
        `CHK(d[0], 1'b1)
        end_test("device_identification_word");
    endtask
    // user code from security bits, user id field zero when blank
    task automatic t_usercode(input logic blank);
        @(negedge core_clk_i);
        sec_reg_i = 32'hB6C5_A3F1;
        otp_blank_i = blank;
        u_tester.scan(1'b1, 16, 128'h2222, d);
        u_tester.scan(1'b0, 128, '0, d);
        for (int k = 0; k < 4; k++)
            `CHK(d[32*k +: 32], {(blank ? 10'h000 : 10'h2DB), 6'h00, SIL_REV})
        end_test("usercode");
    endtask
    // chip access on tile 0 to every target, read data returned
    task automatic t_chipacc();
        logic [TGT_W-1:0] tg;
        logic [42:0] c;
        logic [31:0] rd;
        int n;
        u_tester.scan(1'b1, 16, 128'hF8FF, d);
        for (int t = 0; t < 4; t++) begin
            tg = (t == 1) ? TGT_SWITCH : (t == 2) ? TGT_OTP : TGT_TILE;
            c = {tg, t == 3, 8'h5A + t[7:0], 24'hC0DE00, t[7:0]};
            n = reqs;
            u_tester.scan(1'b0, 46, {83'h0, c, 2'b00}, d);
            if (t > 0) `CHK(d[33:2], rd)
            for (int i = 0; i < 40 && reqs == n; i++) @(negedge core_clk_i);
            `CHK(s_req, {1'b0, c})
            rd = {16'h9E3B, 8'h00, t[7:0]};
            dbg_rdata_i = rd;
            dbg_done_i = 1'b1;
            @(negedge core_clk_i);
            dbg_done_i = 1'b0;
            dbg_rdata_i = ~rd;
        end
        end_test("chipacc");
    endtask
    // extest on tile 0 boundary: ir capture, pad capture, pin drive
    task automatic t_extest();
        u_tester.scan(1'b1, 16, 128'h0FFF, d);
        `CHK(d[15:0], 16'h1111)
        u_tester.scan(1'b0, 11, {117'h0, 8'hC3, 3'h0}, d);
        `CHK(d[10:3], 8'hA5)
        repeat (6) @(negedge core_clk_i);
        `CHK(pin_out_o, 8'hC3)
        end_test("extest");
    endtask
    // test reset held: no output, pins follow core
    task automatic t_trst_hold();
        logic b;
        u_tester.hold_reset();
        @(negedge core_clk_i);
        pin_core_i = 8'h3C;
        for (int i = 0; i < 8; i++) begin
            u_tester.step(i % 3 == 0, i[0], b);
            `CHK({tdo_oe_o, tdo_o}, 2'b00)
        end
        `CHK(pin_out_o, 8'h3C)
        end_test("trst_hold");
    endtask
    task automatic summarize();
        $display("checks %0d mismatches %0d", samples_checked, miscompares);
        if (miscompares == 0 && samples_checked > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask
    // main sequence
    initial begin
        rstn_i = 1'b0;
        pll_lock_i = 1'b0;
        boot_mode_i = 2'h1;
        pin_in_i = 8'hA5;
        pin_core_i = 8'h81;
        sec_reg_i = '0;
        otp_blank_i = 1'b0;
        dbg_done_i = 1'b0;
        dbg_rdata_i = '0;
        repeat (8) @(negedge core_clk_i);
        rstn_i = 1'b1;
        t_boot();
        t_device_identification_word();
        t_usercode(1'b0);
        t_usercode(1'b1);
        t_chipacc();
        t_extest();
        t_trst_hold();
        summarize();
    end
    // watchdog
    initial begin
        #150000;
        miscompares++;
        summarize();
    end
endmodule
